/* rtl/limp_home_stop_recovery_ctrl.sv */
// Limp-home and STOP-exit sequencer with an AXI4-Lite register slave
//
// How it works
// - Lost external clock with monitor on and limp-home allowed switches system clock to VCO minimum.
// - Limp-home forces pll power on, bus PLL select high, module select low, monitor outside STOP.
// - Limp-home flag mirrors mode; each change sets change flag; irq if enabled.
// - Limp-home takes timebase, debug, module clocks from PLL path at minimum VCO.
// - Monitor status sampled each time the 13-stage counter hits 4096.
// - External clock seen at a check leaves limp-home, clears flag, sets change.
// - Leaving limp-home restores saved selects (PLL select only if software left it set) and hands monitor back to enables.
// - With auto and PLL select saved, system clock ramps on PLL after exit.
// - Reset with PLL supply sets monitor enable and pll power, clears no-limp.
// - After power-on the counter runs from VCO; first 4096 ends internal reset.
// - Clock seen during reset period: leave limp-home, count 4096 external, release.
// - No clock by end of count: in normal mode leave reset in limp-home with both flags.
// - PLL supply grounded disables limp-home and PLL ramp (pll power still follows its bit); external clock only.
// - STOP exit follows no-limp, monitor and delay bits; delay is 4096 counts.
// - STOP delay counts timebase ticks from the slow-mode divider.
// - STOP ends on reset, IRQ, XIRQ, key wake-up J or H, CAN wake-up.
// - No limp-home and monitor off: STOP resumes on external clock after delay.
// - No-limp with a monitor enable: STOP is a monitor failure and resets.
// - Limp-home allowed: monitor masked in STOP, exit enters limp-home.
// - Limp-home STOP delay waits 4096, exits normally or stays in limp-home.
// - No-limp with monitor on: clock loss resets via monitor reset vector.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module limp_home_stop_recovery_ctrl #(
  parameter int unsigned CHECK_CYCLES = 4096
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic timebase_tick,
  input wire logic ext_clock_present,
  input wire logic pll_supply,
  input wire logic normal_mode,
  input wire logic stop_request,
  input wire logic wake_irq,
  input wire logic wake_xirq,
  input wire logic wake_key_j,
  input wire logic wake_key_h,
  input wire logic wake_can,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic limp_home_active,
  output logic vco_min_clock_select,
  output logic pll_power_on,
  output logic bus_clock_pll_select,
  output logic module_clock_select,
  output logic clock_monitor_active,
  output logic pll_ramp_enable,
  output logic internal_reset,
  output logic stopped,
  output logic monitor_reset_req,
  output logic limp_home_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0] ext_sync;
    logic [1:0] tb_sync;
    logic [1:0] sup_sync;
    logic [12:0] cnt;
    limp_home_pkg::mode_e mode;
    logic limp;
    logic [8:0] ctrl;
    logic saved_bus_clock_pll_select;
    logic saved_mcs;
    logic limp_home_change_flag;
    logic mon_rst;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [10:0] outs;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic valid_addr(input logic [11:0] a);
    valid_addr = (a == limp_home_pkg::ADDR_CTRL) ||
                 (a == limp_home_pkg::ADDR_FLAG) ||
                 (a == limp_home_pkg::ADDR_STAT);
  endfunction : valid_addr

  logic ext_ok;
  logic tick;
  logic sup_ok;
  logic check_hit;
  logic mon_on;
  logic wake;
  logic tick_rise;

  assign ext_ok = state_r.ext_sync[1];
  assign sup_ok = state_r.sup_sync[1];
  assign tick_rise = state_r.tb_sync[1];
  assign tick = tick_rise;
  assign check_hit = tick && (state_r.cnt ==
    13'(CHECK_CYCLES - 1));
  assign mon_on = state_r.ctrl[limp_home_pkg::CTRL_CME] ||
                  state_r.ctrl[limp_home_pkg::CTRL_FAST_CLOCK_MONITOR_ENABLE];
  assign wake = wake_irq || wake_xirq || wake_key_j || wake_key_h ||
                wake_can;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic lh_next;
    logic [8:0] c;
    lh_next = 1'b0;
    c = 9'h000;
    state_nxt = state_r;
    state_nxt.ext_sync = {state_r.ext_sync[0], ext_clock_present};
    state_nxt.tb_sync = {state_r.tb_sync[0], timebase_tick};
    state_nxt.sup_sync = {state_r.sup_sync[0], pll_supply};
    if (tick) begin
      state_nxt.cnt = 13'(state_r.cnt + 13'h0001);
    end
    lh_next = state_r.limp;
    state_nxt.mon_rst = 1'b0;

    case (state_r.mode)
      limp_home_pkg::ST_PORST: begin
        // VCO drives counter during internal reset
        lh_next = sup_ok && normal_mode;
        // Decide only once synchronisers carry pin values
        if (tick && (ext_ok || !sup_ok)) begin
          lh_next = 1'b0;
          state_nxt.cnt = 13'h0000;
          state_nxt.mode = limp_home_pkg::ST_RESET_EXT;
        end else if (check_hit) begin
          state_nxt.mode = limp_home_pkg::ST_RUN;
          state_nxt.cnt = 13'h0000;
        end
      end
      limp_home_pkg::ST_RESET_EXT: begin
        lh_next = 1'b0;
        if (check_hit && ext_ok) begin
          state_nxt.cnt = 13'h0000;
          state_nxt.mode = limp_home_pkg::ST_RUN;
        end
      end
      limp_home_pkg::ST_RUN: begin
        if (state_r.limp) begin
          if (check_hit && ext_ok) begin
            lh_next = 1'b0;
          end
        end else if (!ext_ok && sup_ok && mon_on) begin
          if (state_r.ctrl[limp_home_pkg::CTRL_NOLH]) begin
            state_nxt.mon_rst = 1'b1;
          end else begin
            lh_next = 1'b1;
          end
        end
        if (stop_request) begin
          if (state_r.ctrl[limp_home_pkg::CTRL_NOLH] && mon_on) begin
            state_nxt.mon_rst = 1'b1;
          end else begin
            state_nxt.mode = limp_home_pkg::ST_STOP;
          end
        end
      end
      limp_home_pkg::ST_STOP: begin
        if (wake) begin
          state_nxt.cnt = 13'h0000;
          if (!state_r.ctrl[limp_home_pkg::CTRL_NOLH] && sup_ok) begin
            lh_next = 1'b1;
          end
          if (state_r.ctrl[limp_home_pkg::CTRL_DLY]) begin
            state_nxt.mode = limp_home_pkg::ST_STOP_DELAY;
          end else begin
            state_nxt.mode = limp_home_pkg::ST_RUN;
          end
        end
      end
      limp_home_pkg::ST_STOP_DELAY: begin
        if (check_hit) begin
          state_nxt.mode = limp_home_pkg::ST_RUN;
          if (ext_ok) begin
            lh_next = 1'b0;
          end
        end
      end
      default: begin
        state_nxt.mode = limp_home_pkg::ST_PORST;
      end
    endcase

    if (!sup_ok) begin
      lh_next = 1'b0;
    end
    if (lh_next && !state_r.limp) begin
      state_nxt.saved_bus_clock_pll_select = state_r.ctrl[limp_home_pkg::CTRL_BUS_CLOCK_PLL_SELECT];
      state_nxt.saved_mcs = state_r.ctrl[limp_home_pkg::CTRL_MCS];
    end
    if (!lh_next && state_r.limp) begin
      // Software may have cleared the PLL select meanwhile
      state_nxt.ctrl[limp_home_pkg::CTRL_BUS_CLOCK_PLL_SELECT] =
        state_r.saved_bus_clock_pll_select && state_r.ctrl[limp_home_pkg::CTRL_BUS_CLOCK_PLL_SELECT];
      state_nxt.ctrl[limp_home_pkg::CTRL_MCS] = state_r.saved_mcs;
    end
    state_nxt.limp = lh_next;

    // Register slave: write
    if (s_axi_awvalid && !state_r.aw_got) begin
      state_nxt.aw_got = 1'b1;
      state_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_r.w_got) begin
      state_nxt.w_got = 1'b1;
      state_nxt.wdata = s_axi_wdata;
      state_nxt.wstrb = s_axi_wstrb;
    end
    if (state_r.aw_got && state_r.w_got && !state_r.bvalid) begin
      state_nxt.aw_got = 1'b0;
      state_nxt.w_got = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = valid_addr(state_r.awaddr) ?
        limp_home_pkg::RESP_OKAY : limp_home_pkg::RESP_SLVERR;
      if (state_r.awaddr == limp_home_pkg::ADDR_CTRL) begin
        c = state_nxt.ctrl;
        if (state_r.wstrb[0]) begin
          c[7:0] = state_r.wdata[7:0];
        end
        if (state_r.wstrb[1]) begin
          c[8] = state_r.wdata[8];
        end
        state_nxt.ctrl = c;
      end else if (state_r.awaddr == limp_home_pkg::ADDR_FLAG) begin
        if (state_r.wstrb[0] && state_r.wdata[limp_home_pkg::FLAG_LIMP_HOME_CHANGE_FLAG]) begin
          state_nxt.limp_home_change_flag = 1'b0; // Write one to clear
        end
      end
    end
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end
    if (lh_next != state_r.limp) begin
      state_nxt.limp_home_change_flag = 1'b1; // set wins over clear
    end

    // Register slave: read
    if (s_axi_arvalid && !state_r.rvalid) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = valid_addr(s_axi_araddr) ?
        limp_home_pkg::RESP_OKAY : limp_home_pkg::RESP_SLVERR;
      state_nxt.rdata = 32'h00000000;
      if (s_axi_araddr == limp_home_pkg::ADDR_CTRL) begin
        state_nxt.rdata = {23'h000000, state_r.ctrl};
      end else if (s_axi_araddr == limp_home_pkg::ADDR_FLAG) begin
        state_nxt.rdata = {30'h00000000, state_r.limp_home_change_flag, state_r.limp};
      end else if (s_axi_araddr == limp_home_pkg::ADDR_STAT) begin
        state_nxt.rdata = {16'h0000, 3'h0, state_r.cnt};
      end
    end else if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end

    // Registered outputs
    state_nxt.outs[0] = lh_next;
    state_nxt.outs[1] = lh_next;
    state_nxt.outs[2] = lh_next ||
      state_nxt.ctrl[limp_home_pkg::CTRL_PLL_POWER_ON];
    state_nxt.outs[3] = lh_next ||
      state_nxt.ctrl[limp_home_pkg::CTRL_BUS_CLOCK_PLL_SELECT];
    state_nxt.outs[4] = !lh_next &&
      state_nxt.ctrl[limp_home_pkg::CTRL_MCS];
    state_nxt.outs[5] = (state_nxt.mode != limp_home_pkg::ST_STOP) &&
      (lh_next || state_nxt.ctrl[limp_home_pkg::CTRL_CME] ||
       state_nxt.ctrl[limp_home_pkg::CTRL_FAST_CLOCK_MONITOR_ENABLE]);
    state_nxt.outs[6] = !lh_next && state_nxt.outs[3] &&
      state_nxt.ctrl[limp_home_pkg::CTRL_AUTO] && sup_ok;
    state_nxt.outs[7] = (state_nxt.mode == limp_home_pkg::ST_PORST) ||
      (state_nxt.mode == limp_home_pkg::ST_RESET_EXT);
    state_nxt.outs[8] = (state_nxt.mode == limp_home_pkg::ST_STOP) ||
      (state_nxt.mode == limp_home_pkg::ST_STOP_DELAY);
    state_nxt.outs[9] = state_nxt.mon_rst;
    state_nxt.outs[10] = state_nxt.limp_home_change_flag &&
      state_nxt.ctrl[limp_home_pkg::CTRL_LIMP_HOME_IRQ_ENABLE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= '0;
      state_r.mode <= limp_home_pkg::ST_PORST;
      state_r.ctrl <= limp_home_pkg::CTRL_RESET;
      state_r.outs <= 11'h084;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  assign limp_home_active = state_r.outs[0];
  assign vco_min_clock_select = state_r.outs[1];
  assign pll_power_on = state_r.outs[2];
  assign bus_clock_pll_select = state_r.outs[3];
  assign module_clock_select = state_r.outs[4];
  assign clock_monitor_active = state_r.outs[5];
  assign pll_ramp_enable = state_r.outs[6];
  assign internal_reset = state_r.outs[7];
  assign stopped = state_r.outs[8];
  assign monitor_reset_req = state_r.outs[9];
  assign limp_home_irq = state_r.outs[10];
  assign s_axi_awready = !state_r.aw_got;
  assign s_axi_wready = !state_r.w_got;
  assign s_axi_bvalid = state_r.bvalid;
  assign s_axi_bresp = state_r.bresp;
  assign s_axi_arready = !state_r.rvalid;
  assign s_axi_rvalid = state_r.rvalid;
  assign s_axi_rdata = state_r.rdata;
  assign s_axi_rresp = state_r.rresp;

endmodule : limp_home_stop_recovery_ctrl
`default_nettype wire

/* rtl/limp_home_pkg.sv */
// Package: register map, field positions, reset values and counts
package limp_home_pkg;
  localparam int unsigned CNT_WIDTH = 13;
  localparam logic [12:0] CHECK_COUNT = 13'h1000;
  localparam int unsigned PERIOD_COUNT = 8192;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FLAG = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam int unsigned CTRL_CME = 0;
  localparam int unsigned CTRL_FAST_CLOCK_MONITOR_ENABLE = 1;
  localparam int unsigned CTRL_NOLH = 2;
  localparam int unsigned CTRL_DLY = 3;
  localparam int unsigned CTRL_PLL_POWER_ON = 4;
  localparam int unsigned CTRL_BUS_CLOCK_PLL_SELECT = 5;
  localparam int unsigned CTRL_MCS = 6;
  localparam int unsigned CTRL_LIMP_HOME_IRQ_ENABLE = 7;
  localparam int unsigned CTRL_AUTO = 8;
  localparam logic [8:0] CTRL_RESET = 9'h011;
  localparam int unsigned FLAG_LIMP_HOME_FLAG = 0;
  localparam int unsigned FLAG_LIMP_HOME_CHANGE_FLAG = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_PORST, ST_RESET_EXT, ST_RUN, ST_STOP, ST_STOP_DELAY
  } mode_e;
endpackage : limp_home_pkg

/* testbench/ext_clock_src.sv */
// Model: external clock source with start-up delay
`timescale 1ns/100ps
`default_nettype none
module ext_clock_src #(
  parameter int STARTUP = 20
) (
  input wire logic aclk,
  input wire logic run,
  output logic present,
  output logic tick
);
  int cnt = 0;
  initial begin
    present = 1'b0;
    tick = 1'b0;
  end
  // Timebase runs from crystal or VCO alike
  always @(posedge aclk) begin
    tick <= 1'b1;
    if (!run) begin
      cnt <= 0;
      present <= 1'b0;
    end else if (cnt < STARTUP) begin
      cnt <= cnt + 1;
    end else begin
      present <= 1'b1;
    end
  end
endmodule : ext_clock_src
`default_nettype wire

/* testbench/limp_home_checker_assertions.sv */
// Checker: limp-home relations at the block's ports
`timescale 1ns/100ps
`default_nettype none
module limp_home_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_clock_present,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic limp_home_active,
  input wire logic vco_min_clock_select,
  input wire logic pll_power_on,
  input wire logic bus_clock_pll_select,
  input wire logic module_clock_select,
  input wire logic clock_monitor_active,
  input wire logic pll_ramp_enable,
  input wire logic stopped,
  input wire logic monitor_reset_req,
  input wire logic limp_home_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////
  sequence s_steady;
    limp_home_active && $past(limp_home_active);
  endsequence
  sequence s_left;
    limp_home_active ##1 !limp_home_active;
  endsequence
  property p_force;
    s_steady |-> pll_power_on && bus_clock_pll_select
      && !module_clock_select && !pll_ramp_enable;
  endproperty
  a_force: assert property (p_force)
    else $error("Limp-home forcing missing");
  property p_vco;
    1'b1 |-> vco_min_clock_select == limp_home_active;
  endproperty
  a_vco: assert property (p_vco)
    else $error("VCO select differs from limp-home");
  property p_mon;
    s_steady and !stopped && !$past(stopped) |-> clock_monitor_active;
  endproperty
  a_mon: assert property (p_mon)
    else $error("Monitor off in limp-home");
  property p_mask;
    stopped && !limp_home_active |-> !clock_monitor_active;
  endproperty
  a_mask: assert property (p_mask)
    else $error("Monitor active in STOP");
  property p_ramp;
    pll_ramp_enable |-> bus_clock_pll_select;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("Ramp without PLL select");
  property p_exit;
    s_left |-> $past(ext_clock_present, 3);
  endproperty
  a_exit: assert property (p_exit)
    else $error("Limp-home left without clock");
  property p_irq;
    limp_home_irq && !s_axi_awvalid && !s_axi_wvalid && !s_axi_bvalid
      && !$past(s_axi_wvalid) && !$past(s_axi_bvalid) |=> limp_home_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt dropped without write");
  property p_mrr;
    monitor_reset_req |-> !stopped;
  endproperty
  a_mrr: assert property (p_mrr)
    else $error("Monitor reset while stopped");
endmodule : limp_home_checker
bind limp_home_stop_recovery_ctrl limp_home_checker u_limp_home_checker (.*);
`default_nettype wire

/* testbench/limp_home_stop_recovery_ctrl_bench.sv */
// Bench: limp-home and STOP recovery sequencing
`timescale 1ns/100ps
`default_nettype none
module limp_home_stop_recovery_ctrl_bench;
  logic aclk, aresetn, clk_en, timebase_tick, ext_clock_present, pll_supply;
  logic normal_mode, stop_request, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, limp_home_active, vco_min_clock_select;
  logic pll_power_on, bus_clock_pll_select, module_clock_select, xon;
  logic clock_monitor_active, pll_ramp_enable, internal_reset, stopped;
  logic monitor_reset_req, limp_home_irq;
  wire wake_irq, wake_xirq, wake_key_j, wake_key_h, wake_can;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs_v;
  logic [4:0] wk;
  logic [2:0] obs;
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  localparam logic [11:0] RA [3] = '{12'h000, 12'h004, 12'h00c};
  // Row 0 clears the bus PLL select while in limp-home
  localparam logic [31:0] RW [3] = '{32'h191, 32'h0, 32'h1};
  localparam logic [31:0] RX [3] = '{32'h191, 32'h3, 32'h0};
  localparam logic [1:0] RS [3] = '{2'h0, 2'h0, 2'h2};
  assign {wake_can, wake_key_h, wake_key_j, wake_xirq, wake_irq} = wk;
  assign obs = {monitor_reset_req, stopped, limp_home_active};
  limp_home_stop_recovery_ctrl u_limp_home_stop_recovery_ctrl (.*);
  ext_clock_src u_ext_clock_src (.aclk(aclk), .run(xon),
    .present(ext_clock_present), .tick(timebase_tick));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  //////////////////////////////
  task results();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Bench timeout stands in for the watchdog
  task tmo(input int i, input int lim);
    if (i >= lim) begin
      fail_count++;
      results();
    end
  endtask : tmo
  task wt(input int b, input logic v, input int lim, output int c);
    for (c = 0; c < lim && obs[b] !== v; c++) @(posedge aclk);
    tmo(c, lim);
  endtask : wt
  task wr(input logic [11:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs_v = s_axi_bresp;
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge aclk);
    tmo(i, 40);
  endtask : wr
  task rd(input logic [11:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_v = s_axi_rdata;
    rs_v = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    tmo(i, 40);
  endtask : rd
  task stp();
    stop_request <= 1'b1;
    @(posedge aclk);
    stop_request <= 1'b0;
  endtask : stp
  //////////////////////////////
  initial begin
    {aresetn, stop_request, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, xon, wk} = '0;
    {clk_en, pll_supply, normal_mode, s_axi_wstrb} = 7'h7f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (10) @(posedge aclk);
    chk("rst_int", internal_reset, 1);
    chk("rst_pll", pll_power_on, 1);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(limp_home_pkg::ADDR_CTRL);
    chk("ctrl_rst", rd_v, 32'h011);
    wt(0, 1'b1, 6000, n);
    for (n = 0; n < 6000 && internal_reset !== 1'b0; n++) @(posedge aclk);
    tmo(n, 6000);
    rd(limp_home_pkg::ADDR_FLAG);
    chk("flag_lh", rd_v, 32'h3);
    chk("int_rst", internal_reset, 0);
    for (int r = 0; r < 3; r++) begin
      wr(RA[r], RW[r]);
      chk("row_bresp", rs_v, RS[r]);
      rd(RA[r]);
      chk("row_rdata", rd_v, RX[r]);
      chk("row_rresp", rs_v, RS[r]);
    end
    chk("irq_on", limp_home_irq, 1);
    wr(limp_home_pkg::ADDR_FLAG, 32'h2);
    chk("irq_off", limp_home_irq, 0);
    xon <= 1'b1;
    wt(0, 1'b0, 10000, n);
    rd(limp_home_pkg::ADDR_FLAG);
    chk("flag_back", rd_v, 32'h2);
    chk("irq_back", limp_home_irq, 1);
    chk("bus_clock_pll_select_back", bus_clock_pll_select, 0);
    chk("mcs_back", module_clock_select, 0);
    chk("ramp", pll_ramp_enable, 0);
    for (int w = 0; w < 5; w++) begin
      stp();
      wt(1, 1'b1, 10, n);
      chk("stop_mon", clock_monitor_active, 0);
      wk <= 5'h01 << w;
      wt(1, 1'b0, 20, n);
      wk <= 5'h00;
      chk("stop_lh", limp_home_active, 1);
    end
    wt(0, 1'b0, 10000, n);
    wr(limp_home_pkg::ADDR_CTRL, 32'h00c);
    stp();
    wt(1, 1'b1, 10, n);
    wk <= 5'h01;
    @(posedge aclk);
    wk <= 5'h00;
    wt(1, 1'b0, 9000, n);
    chk("dly_len", n >= 4090 && n < 4200, 1);
    chk("dly_lh", limp_home_active, 0);
    wr(limp_home_pkg::ADDR_CTRL, 32'h005);
    stp();
    wt(2, 1'b1, 10, n);
    chk("mrr_run", stopped, 0);
    results();
  end
endmodule : limp_home_stop_recovery_ctrl_bench
`default_nettype wire
